//--- bench/lcd_window_pip_regs_test.sv
// lcd_window_pip_regs_test: self-checking bench for the window regs
// assumes design files and lwp_chk compiled first; ahb master is here
`timescale 1ns/1ps

module lcd_window_pip_regs_test;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        endian_config_strap = 1'b0;
    wire         hready;
    logic        vnd_period = 1'b0, line_start = 1'b0, frame_start = 1'b0;
    logic        pix_valid = 1'b0, hresp, hreadyout, pix_inv, ovl_active;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, panel_select;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] pix_in = 16'h0, pix_out;
    logic [16:0] main_fetch_addr, ovl_fetch_addr;
    logic [10:0] ovl_x0_px, ovl_x1_px, ovl_y0_px, ovl_y1_px;
    int          miscompares = 0, checks_done = 0;
    logic [7:0]  row_a [7] = '{8'h44, 8'h48, 8'h50, 8'h54, 8'h58, 8'h5c,
                               8'h60};
    logic [31:0] row_e [7] = '{32'h3ff, 32'h10f, 32'h1ffff, 32'h3ff,
                               32'h3ff03ff, 32'h3ff03ff, 32'h0};

    // 50 mhz clock
    always #10 hclk = ~hclk;

    lcd_window_pip_regs i_lcd_window_pip_regs (.*);
    assign hready = hreadyout;

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // one single transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer

    // one-cycle pulse on vnd_period, line_start, frame_start
    task automatic strobe(input logic [2:0] m);
        @(posedge hclk);
        {vnd_period, line_start, frame_start} <= m;
        @(posedge hclk);
        {vnd_period, line_start, frame_start} <= 3'h0;
        repeat (4) @(posedge hclk);
        #1;
    endtask : strobe

    task automatic pix(input logic [15:0] d, input logic [15:0] eo,
                       input logic ei);
        repeat (2) @(posedge hclk);
        pix_valid <= 1'b1;
        pix_in    <= d;
        @(posedge hclk);
        pix_valid <= 1'b0;
        #1;
        chk({15'h0, pix_inv, pix_out}, {15'h0, ei, eo});
    endtask : pix

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // watchdog against a hung handshake
    initial
    begin
        #100000;
        miscompares++;
        final_report();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b0, row_a[i], 32'h0);
            chk(rd, 32'h0);
        end
        $display("reset test done");
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b1, row_a[i], 32'hffffffff);
            xfer(1'b0, row_a[i], 32'h0);
            chk(rd, row_e[i]);
        end
        $display("row test done");
        for (int c = 0; c < 16; c++)
        begin
            xfer(1'b1, 8'h48, c);
            repeat (2) @(posedge hclk);
            #1;
            chk({29'h0, panel_select}, (c < 5) ? c : 0);
        end
        $display("panel test done");
        xfer(1'b1, 8'h48, 32'h101);
        pix(16'h0000, 16'h0000, 1'b0);
        pix(16'hffff, 16'h0000, 1'b1);
        pix(16'h00ff, 16'h00ff, 1'b0);
        xfer(1'b1, 8'h48, 32'h103);
        pix(16'hff00, 16'hff00, 1'b0);
        $display("invert test done");
        xfer(1'b1, 8'h70, 32'h0);
        xfer(1'b1, 8'h58, 32'h00020001);
        xfer(1'b1, 8'h5c, 32'h00050003);
        strobe(3'h0);
        chk({10'h0, ovl_x0_px, ovl_y1_px}, 32'h0);
        strobe(3'h4);
        chk({10'h0, ovl_x0_px, ovl_x1_px}, {10'h0, 11'h020, 11'h040});
        chk({10'h0, ovl_y0_px, ovl_y1_px}, {10'h0, 11'h003, 11'h005});
        xfer(1'b1, 8'h70, 32'h14);
        strobe(3'h0);
        chk({10'h0, ovl_x0_px, ovl_y0_px}, {10'h0, 11'h001, 11'h006});
        $display("commit test done");
        xfer(1'b1, 8'h10, 32'h00080000);
        xfer(1'b1, 8'h44, 32'h10);
        xfer(1'b1, 8'h50, 32'h100);
        xfer(1'b1, 8'h54, 32'h20);
        strobe(3'h1);
        chk({15'h0, ovl_fetch_addr}, 32'h100);
        chk({31'h0, ovl_active}, 32'h1);
        strobe(3'h2);
        chk({15'h0, main_fetch_addr}, 32'h10);
        chk({15'h0, ovl_fetch_addr}, 32'h120);
        xfer(1'b1, 8'h10, 32'h0);
        strobe(3'h2);
        chk({15'h0, ovl_fetch_addr}, 32'h120);
        chk({31'h0, ovl_active}, 32'h0);
        $display("fetch test done");
        // reset in mid-run with the big endian strap set across it
        @(posedge hclk);
        hresetn <= 1'b0;
        endian_config_strap <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        chk({12'h0, panel_select, ovl_fetch_addr}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, 8'h44, 32'h0);
        chk(rd, 32'h0);
        $display("mid reset test done");
        xfer(1'b1, 8'h58, 32'h03ff0000);
        xfer(1'b1, 8'h5c, 32'h03ff0000);
        strobe(3'h4);
        chk({21'h0, ovl_x1_px}, 32'h400);
        chk({21'h0, ovl_y1_px}, 32'h3ff);
        $display("endian test done");
        final_report();
    end
endmodule : lcd_window_pip_regs_test

//--- bench/lwp_chk.sv
// lwp_chk: port assertions for the window register bank
// assumes binding onto lcd_window_pip_regs, single clock hclk
`timescale 1ns/1ps

module lwp_chk
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        frame_start,
    input wire logic        pix_valid,
    input wire logic [15:0] pix_in,
    input wire logic [15:0] pix_out,
    input wire logic        pix_inv,
    input wire logic [2:0]  panel_select,
    input wire logic [16:0] main_fetch_addr,
    input wire logic [16:0] ovl_fetch_addr,
    input wire logic        ovl_active,
    input wire logic [10:0] ovl_x1_px,
    input wire logic [10:0] ovl_y1_px
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready");
    property p_inv_val; pix_valid |=> pix_out ==
        (pix_inv ? ~$past(pix_in) : $past(pix_in)); endproperty
    a_inv_val: assert property (p_inv_val)
        else $error("pixel out not in or inverse");
    property p_inv_off; pix_valid && panel_select != 3'h1
        && panel_select != 3'h2 |=> !pix_inv; endproperty
    a_inv_off: assert property (p_inv_off)
        else $error("invert on other panel type");
    property p_psel; panel_select <= 3'h4; endproperty
    a_psel: assert property (p_psel) else $error("bad panel");
    property p_frame; frame_start |=> main_fetch_addr == 17'h0; endproperty
    a_frame: assert property (p_frame) else $error("no reload");
    property p_ovl_hold; !ovl_active ##1 !ovl_active
        |-> $stable(ovl_fetch_addr); endproperty
    a_ovl_hold: assert property (p_ovl_hold)
        else $error("overlay fetch moved while off");
    property p_x_clamp; ovl_x1_px <= 11'h400; endproperty
    a_x_clamp: assert property (p_x_clamp) else $error("x over");
    property p_y_clamp; ovl_y1_px <= 11'h400; endproperty
    a_y_clamp: assert property (p_y_clamp) else $error("y over");
endmodule : lwp_chk

bind lcd_window_pip_regs lwp_chk i_lwp_chk (.*);

//--- verilog/lcd_window_pip_regs.sv
// lcd_window_pip_regs: main and overlay window register bank, ahb-lite
// assumes one clock, vertical non-display flag and strap synchronous
//
// What this block does
// - main stride is ten bits, in 32-bit words, line start to line start.
// - fetch addresses step by the programmed stride, giving a virtual view.
// - codes 1..4 select TFT 2, 3, 4 and vendor TFT; others reserved.
// - overlay start address is a 17-bit double-word address.
// - overlay start and stride act only while overlay enable, control bit 19, is set.
// - overlay stride is ten bits, in words, between overlay lines.
// - coordinate writes apply after y write, at next vertical non-display.
// - commit byte is bits 31-24 little endian, bits 7-0 big endian.
// - coordinate registers hold end in bits 25-16, start in bits 9-0.
// - at 0 and 180 degrees an x unit is one word of pixels.
// - at 90 and 270 degrees an x unit is one line.
// - y counts lines at 0/180, word pixel groups at 90/270.
// - scaled coordinates beyond the 1024 panel limit clamp placement at 1024.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module lcd_window_pip_regs
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        endian_config_strap,
    input  wire logic        vnd_period,
    input  wire logic        line_start,
    input  wire logic        frame_start,
    input  wire logic        pix_valid,
    input  wire logic [15:0] pix_in,
    output logic      [15:0] pix_out,
    output logic             pix_inv,
    output logic      [2:0]  panel_select,
    output logic      [16:0] main_fetch_addr,
    output logic      [16:0] ovl_fetch_addr,
    output logic             ovl_active,
    output logic      [10:0] ovl_x0_px,
    output logic      [10:0] ovl_x1_px,
    output logic      [10:0] ovl_y0_px,
    output logic      [10:0] ovl_y1_px
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [9:0]  main_stride_r,  main_stride_nxt;
    logic [3:0]  ext_type_r,     ext_type_nxt;
    logic        inv_en_r,       inv_en_nxt;
    logic [16:0] ovl_start_r,    ovl_start_nxt;
    logic [9:0]  ovl_stride_r,   ovl_stride_nxt;
    logic [25:0] x_pend_r,       x_pend_nxt;
    logic [25:0] y_pend_r,       y_pend_nxt;
    logic [25:0] x_live_r,       x_live_nxt;
    logic [25:0] y_live_r,       y_live_nxt;
    logic [31:0] ctrl_r,         ctrl_nxt;
    logic [1:0]  basic_type_r,   basic_type_nxt;
    logic [2:0]  bpp_r,          bpp_nxt;
    logic [1:0]  rot_r,          rot_nxt;
    logic [16:0] main_base_r,    main_base_nxt;
    logic [16:0] main_addr_r,    main_addr_nxt;
    logic [16:0] ovl_addr_r,     ovl_addr_nxt;
    logic [2:0]  psel_r,         psel_nxt;
    logic        ovl_act_r,      ovl_act_nxt;
    logic        big_end_r;
    lwp_pkg::lwp_commit_e cst_r, cst_nxt;

    // ahb data-phase capture
    logic        dp_wr_r,  dp_wr_nxt;
    logic [3:0]  dp_lane_r, dp_lane_nxt;
    logic [7:0]  dp_ofs_r, dp_ofs_nxt;
    logic [31:0] rdata_r,  rdata_nxt;

    logic        wr_go;
    logic        commit_byte;
    logic        inv_active;
    logic        rot_side;
    logic [10:0] sx0, sx1, sy0, sy1;

    // ------------------------------------------------------------------
    // ahb-lite slave: zero wait, always okay
    // ------------------------------------------------------------------
    // address phase latched for the following data phase
    always_comb
    begin
        dp_wr_nxt   = 1'b0;
        dp_lane_nxt = 4'h0;
        dp_ofs_nxt  = dp_ofs_r;
        if (hsel && hready && htrans[1])
        begin
            dp_wr_nxt  = hwrite;
            dp_ofs_nxt = {haddr[7:2], 2'b00};
            // byte lanes that this transfer carries
            unique case (hsize[1:0])
                2'b00:   dp_lane_nxt = 4'h1 << haddr[1:0];
                2'b01:   dp_lane_nxt = haddr[1] ? 4'hc : 4'h3;
                default: dp_lane_nxt = 4'hf;
            endcase
        end
    end

    assign wr_go = dp_wr_r;

    // little endian triggers on the top byte, big endian on the bottom
    assign commit_byte = big_end_r ? dp_lane_r[0] : dp_lane_r[3];

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            unique case ({haddr[7:2], 2'b00})
                lwp_pkg::MAIN_STRIDE_OFS: rdata_nxt[9:0] = main_stride_r;
                lwp_pkg::EXT_PANEL_OFS:
                begin
                    rdata_nxt[lwp_pkg::INV_EN_BIT] = inv_en_r;
                    rdata_nxt[3:0] = ext_type_r;
                end
                lwp_pkg::OVL_START_OFS:  rdata_nxt[16:0] = ovl_start_r;
                lwp_pkg::OVL_STRIDE_OFS: rdata_nxt[9:0]  = ovl_stride_r;
                lwp_pkg::OVL_X_OFS:      rdata_nxt[25:0] = x_pend_r;
                lwp_pkg::OVL_Y_OFS:      rdata_nxt[25:0] = y_pend_r;
                lwp_pkg::CTRL_OFS:       rdata_nxt = ctrl_r;
                lwp_pkg::BASIC_PANEL_OFS: rdata_nxt[1:0] = basic_type_r;
                lwp_pkg::VIEW_CFG_OFS:
                begin
                    rdata_nxt[2:0] = bpp_r;
                    rdata_nxt[5:4] = rot_r;
                end
                lwp_pkg::STATUS_OFS:
                begin
                    rdata_nxt[2:0] = psel_r;
                    rdata_nxt[4]   = (cst_r != lwp_pkg::LWP_IDLE);
                    rdata_nxt[5]   = ovl_act_r;
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // register writes and coordinate commit
    // ------------------------------------------------------------------
    always_comb
    begin
        main_stride_nxt = main_stride_r;
        ext_type_nxt    = ext_type_r;
        inv_en_nxt      = inv_en_r;
        ovl_start_nxt   = ovl_start_r;
        ovl_stride_nxt  = ovl_stride_r;
        x_pend_nxt      = x_pend_r;
        y_pend_nxt      = y_pend_r;
        ctrl_nxt        = ctrl_r;
        basic_type_nxt  = basic_type_r;
        bpp_nxt         = bpp_r;
        rot_nxt         = rot_r;
        main_base_nxt   = main_base_r;
        if (wr_go)
        begin
            unique case (dp_ofs_r)
                lwp_pkg::MAIN_STRIDE_OFS:
                    main_stride_nxt = hwdata[9:0];
                lwp_pkg::EXT_PANEL_OFS:
                begin
                    inv_en_nxt   = hwdata[lwp_pkg::INV_EN_BIT];
                    ext_type_nxt = hwdata[3:0];
                end
                lwp_pkg::OVL_START_OFS:
                    ovl_start_nxt = hwdata[16:0];
                lwp_pkg::OVL_STRIDE_OFS:
                    ovl_stride_nxt = hwdata[9:0];
                lwp_pkg::OVL_X_OFS:
                    x_pend_nxt = {hwdata[25:16], 6'h00, hwdata[9:0]};
                lwp_pkg::OVL_Y_OFS:
                    y_pend_nxt = {hwdata[25:16], 6'h00, hwdata[9:0]};
                lwp_pkg::CTRL_OFS:        ctrl_nxt = hwdata;
                lwp_pkg::BASIC_PANEL_OFS: basic_type_nxt = hwdata[1:0];
                lwp_pkg::VIEW_CFG_OFS:
                begin
                    bpp_nxt = hwdata[2:0];
                    rot_nxt = hwdata[5:4];
                end
                default: main_base_nxt = main_base_r;
            endcase
        end
    end

    // commit machine: arm on y write, apply in vertical non-display
    always_comb
    begin
        cst_nxt    = cst_r;
        x_live_nxt = x_live_r;
        y_live_nxt = y_live_r;
        unique case (cst_r)
            lwp_pkg::LWP_IDLE:
                if (wr_go && dp_ofs_r == lwp_pkg::OVL_Y_OFS && commit_byte)
                    cst_nxt = lwp_pkg::LWP_ARMED;
            lwp_pkg::LWP_ARMED:
                if (vnd_period)
                    cst_nxt = lwp_pkg::LWP_APPLY;
            lwp_pkg::LWP_APPLY:
            begin
                x_live_nxt = x_pend_r;
                y_live_nxt = y_pend_r;
                cst_nxt    = lwp_pkg::LWP_IDLE;
                // a y write landing now re-arms for the next blanking
                if (wr_go && dp_ofs_r == lwp_pkg::OVL_Y_OFS && commit_byte)
                    cst_nxt = lwp_pkg::LWP_ARMED;
            end
            default: cst_nxt = lwp_pkg::LWP_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // panel selection, overlay enable and fetch addresses
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (ext_type_r)
            lwp_pkg::EXT_TFT2:   psel_nxt = lwp_pkg::PSEL_TFT2;
            lwp_pkg::EXT_TFT3:   psel_nxt = lwp_pkg::PSEL_TFT3;
            lwp_pkg::EXT_TFT4:   psel_nxt = lwp_pkg::PSEL_TFT4;
            lwp_pkg::EXT_VENDOR: psel_nxt = lwp_pkg::PSEL_VENDOR;
            default:             psel_nxt = lwp_pkg::PSEL_BASIC;
        endcase
        ovl_act_nxt = ctrl_r[lwp_pkg::OVL_EN_BIT];
        // main window walks by its stride, giving a virtual view
        main_addr_nxt = main_addr_r;
        if (frame_start)
            main_addr_nxt = main_base_r;
        else if (line_start)
            main_addr_nxt = main_addr_r + {7'h00, main_stride_r};
        // overlay fetch holds still unless the overlay is enabled
        ovl_addr_nxt = ovl_addr_r;
        if (ctrl_r[lwp_pkg::OVL_EN_BIT])
        begin
            if (frame_start)
                ovl_addr_nxt = ovl_start_r;
            else if (line_start)
                ovl_addr_nxt = ovl_addr_r + {7'h00, ovl_stride_r};
        end
    end

    // invert acts only on the two tft types that support it
    assign inv_active = inv_en_r && (psel_r == lwp_pkg::PSEL_TFT2 ||
                                     psel_r == lwp_pkg::PSEL_TFT3);

    // rotated views swap which axis counts in words
    assign rot_side = rot_r[0];

    lwp_unit_scale u_sx0 (.coord(x_live_r[9:0]), .bpp(bpp_r),
        .word_axis(!rot_side), .scaled(sx0));
    lwp_unit_scale u_sx1 (.coord(x_live_r[25:16]), .bpp(bpp_r),
        .word_axis(!rot_side), .scaled(sx1));
    lwp_unit_scale u_sy0 (.coord(y_live_r[9:0]), .bpp(bpp_r),
        .word_axis(rot_side), .scaled(sy0));
    lwp_unit_scale u_sy1 (.coord(y_live_r[25:16]), .bpp(bpp_r),
        .word_axis(rot_side), .scaled(sy1));

    lwp_invert u_inv
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .active    (inv_active),
        .pix_valid (pix_valid),
        .pix_in    (pix_in),
        .pix_out   (pix_out),
        .pix_inv   (pix_inv)
    );

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // strap resampled on every clock outside reset by a clocked process
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            big_end_r <= 1'b0;
        else
            big_end_r <= endian_config_strap;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            main_stride_r <= 10'h000;
            ext_type_r    <= 4'h0;
            inv_en_r      <= 1'b0;
            ovl_start_r   <= 17'h00000;
            ovl_stride_r  <= 10'h000;
            x_pend_r      <= 26'h0000000;
            y_pend_r      <= 26'h0000000;
            x_live_r      <= 26'h0000000;
            y_live_r      <= 26'h0000000;
            ctrl_r        <= lwp_pkg::REG_RESET;
            basic_type_r  <= 2'h0;
            bpp_r         <= 3'h0;
            rot_r         <= 2'h0;
            main_base_r   <= 17'h00000;
            main_addr_r   <= 17'h00000;
            ovl_addr_r    <= 17'h00000;
            psel_r        <= 3'h0;
            ovl_act_r     <= 1'b0;
            cst_r         <= lwp_pkg::LWP_IDLE;
            dp_wr_r       <= 1'b0;
            dp_lane_r     <= 4'h0;
            dp_ofs_r      <= 8'h00;
            rdata_r       <= 32'h0000_0000;
            ovl_x0_px     <= 11'h000;
            ovl_x1_px     <= 11'h000;
            ovl_y0_px     <= 11'h000;
            ovl_y1_px     <= 11'h000;
        end
        else
        begin
            main_stride_r <= main_stride_nxt;
            ext_type_r    <= ext_type_nxt;
            inv_en_r      <= inv_en_nxt;
            ovl_start_r   <= ovl_start_nxt;
            ovl_stride_r  <= ovl_stride_nxt;
            x_pend_r      <= x_pend_nxt;
            y_pend_r      <= y_pend_nxt;
            x_live_r      <= x_live_nxt;
            y_live_r      <= y_live_nxt;
            ctrl_r        <= ctrl_nxt;
            basic_type_r  <= basic_type_nxt;
            bpp_r         <= bpp_nxt;
            rot_r         <= rot_nxt;
            main_base_r   <= main_base_nxt;
            main_addr_r   <= main_addr_nxt;
            ovl_addr_r    <= ovl_addr_nxt;
            psel_r        <= psel_nxt;
            ovl_act_r     <= ovl_act_nxt;
            cst_r         <= cst_nxt;
            dp_wr_r       <= dp_wr_nxt;
            dp_lane_r     <= dp_lane_nxt;
            dp_ofs_r      <= dp_ofs_nxt;
            rdata_r       <= rdata_nxt;
            ovl_x0_px     <= sx0;
            ovl_x1_px     <= sx1;
            ovl_y0_px     <= sy0;
            ovl_y1_px     <= sy1;
        end
    end

    assign hrdata          = rdata_r;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign panel_select    = psel_r;
    assign main_fetch_addr = main_addr_r;
    assign ovl_fetch_addr  = ovl_addr_r;
    assign ovl_active      = ovl_act_r;

endmodule : lcd_window_pip_regs

//--- verilog/lwp_invert.sv
// lwp_invert: compare-and-invert of pixel data against the previous pixel
// assumes one pixel word per enable; clocked by the register clock
`timescale 1ns/1ps

module lwp_invert
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        active,
    input  wire logic        pix_valid,
    input  wire logic [15:0] pix_in,
    output logic      [15:0] pix_out,
    output logic             pix_inv
);

    logic [15:0] prev_r;
    logic [15:0] prev_nxt;
    logic [15:0] out_r;
    logic [15:0] out_nxt;
    logic        inv_r;
    logic        inv_nxt;
    logic [4:0]  ones;
    logic [15:0] diff;

    // count toggles against the last sent word; invert when over half
    always_comb
    begin
        diff     = pix_in ^ prev_r;
        ones     = 5'h00;
        for (int i = 0; i < 16; i++)
            ones = ones + {4'h0, diff[i]};
        prev_nxt = prev_r;
        out_nxt  = out_r;
        inv_nxt  = inv_r;
        if (pix_valid)
        begin
            if (active && ones > 5'h08)
            begin
                out_nxt = ~pix_in;
                inv_nxt = 1'b1;
            end
            else
            begin
                out_nxt = pix_in;
                inv_nxt = 1'b0;
            end
            prev_nxt = out_nxt;
        end
    end

    // registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_r <= 16'h0000;
            out_r  <= 16'h0000;
            inv_r  <= 1'b0;
        end
        else
        begin
            prev_r <= prev_nxt;
            out_r  <= out_nxt;
            inv_r  <= inv_nxt;
        end
    end

    assign pix_out = out_r;
    assign pix_inv = inv_r;

endmodule : lwp_invert

//--- verilog/lwp_pkg.sv
// lwp_pkg: register map, field layout and encodings for the window regs
// assumes a 32-bit ahb-lite slave with word-aligned registers
package lwp_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] MAIN_STRIDE_OFS   = 8'h44;
    localparam logic [7:0] EXT_PANEL_OFS     = 8'h48;
    localparam logic [7:0] OVL_START_OFS     = 8'h50;
    localparam logic [7:0] OVL_STRIDE_OFS    = 8'h54;
    localparam logic [7:0] OVL_X_OFS         = 8'h58;
    localparam logic [7:0] OVL_Y_OFS         = 8'h5c;
    localparam logic [7:0] CTRL_OFS          = 8'h10;
    localparam logic [7:0] BASIC_PANEL_OFS   = 8'h0c;
    localparam logic [7:0] VIEW_CFG_OFS      = 8'h70;
    localparam logic [7:0] STATUS_OFS        = 8'h74;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int STRIDE_W      = 10;
    localparam int ADDR_W        = 17;
    localparam int COORD_W       = 10;
    localparam int END_LSB       = 16;
    localparam int INV_EN_BIT    = 8;
    localparam int EXT_TYPE_W    = 4;
    localparam int OVL_EN_BIT    = 19;
    localparam int BASIC_TYPE_W  = 2;
    localparam int BPP_W         = 3;
    localparam int ROT_W         = 2;
    localparam int ROT_LSB       = 4;
    localparam int PIX_W         = 16;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // extended panel codes (0101..1111 reserved)
    // ------------------------------------------------------------------
    localparam logic [3:0] EXT_NONE    = 4'h0;
    localparam logic [3:0] EXT_TFT2    = 4'h1;
    localparam logic [3:0] EXT_TFT3    = 4'h2;
    localparam logic [3:0] EXT_TFT4    = 4'h3;
    localparam logic [3:0] EXT_VENDOR  = 4'h4;

    // effective panel selection driven to the timing logic
    localparam logic [2:0] PSEL_BASIC  = 3'h0;
    localparam logic [2:0] PSEL_TFT2   = 3'h1;
    localparam logic [2:0] PSEL_TFT3   = 3'h2;
    localparam logic [2:0] PSEL_TFT4   = 3'h3;
    localparam logic [2:0] PSEL_VENDOR = 3'h4;

    // colour depth codes: pixels per word = 32 >> code
    localparam logic [2:0] BPP1  = 3'h0;
    localparam logic [2:0] BPP2  = 3'h1;
    localparam logic [2:0] BPP4  = 3'h2;
    localparam logic [2:0] BPP8  = 3'h3;
    localparam logic [2:0] BPP16 = 3'h4;

    // rotation codes
    localparam logic [1:0] ROT0   = 2'h0;
    localparam logic [1:0] ROT90  = 2'h1;
    localparam logic [1:0] ROT180 = 2'h2;
    localparam logic [1:0] ROT270 = 2'h3;

    // panel size limit, in pixels and lines
    localparam logic [10:0] PANEL_MAX = 11'h400;

    typedef enum logic [2:0] {
        LWP_IDLE    = 3'b001,
        LWP_ARMED   = 3'b010,
        LWP_APPLY   = 3'b100
    } lwp_commit_e;

endpackage : lwp_pkg

//--- verilog/lwp_unit_scale.sv
// lwp_unit_scale: turns a window coordinate into pixels or lines
// assumes bpp and rotation codes from lwp_pkg; result clamps at panel size
`timescale 1ns/1ps

module lwp_unit_scale
(
    input  wire logic [9:0]  coord,
    input  wire logic [2:0]  bpp,
    input  wire logic        word_axis,
    output logic      [10:0] scaled
);

    logic [15:0] wide;

    // word axis counts whole words of pixels, the other axis single lines
    always_comb
    begin
        if (word_axis)
            wide = {6'h00, coord} << (3'h5 - bpp);
        else
            wide = {6'h00, coord};
        // results beyond panel size clamp to PANEL_MAX
        if (wide > {5'h00, lwp_pkg::PANEL_MAX})
            scaled = lwp_pkg::PANEL_MAX;
        else
            scaled = wide[10:0];
    end

endmodule : lwp_unit_scale
